/* hw/tcu_tick_gen.sv */
`timescale 1ns/100ps
module tcu_tick_gen
   import tcu_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   reset,
   input  wire logic   clk_en,
   input  wire logic [2:0] clock_select_field,
   input  wire logic   external_count_input,
   tcu_tick_if.src     tk
);
   logic [TCU_PRE_WIDTH-1:0] pre_q;
   logic ext_s1_q, ext_s2_q, ext_s3_q, tick_q;
   logic ext_rise, ext_fall, tick_d;

   assign ext_rise = ext_s2_q & ~ext_s3_q;
   assign ext_fall = ~ext_s2_q & ext_s3_q;
   // Tick source follows the select code; code zero stops the timer.
   always_comb begin
      unique case (clock_select_field)
         TCU_CS_STOP:     tick_d = 1'b0;
         TCU_CS_DIV1:     tick_d = 1'b1;
         TCU_CS_DIV8:     tick_d = &pre_q[2:0];
         TCU_CS_DIV64:    tick_d = &pre_q[5:0];
         TCU_CS_DIV256:   tick_d = &pre_q[7:0];
         TCU_CS_DIV1024:  tick_d = &pre_q[9:0];
         TCU_CS_EXT_FALL: tick_d = ext_fall;
         default:         tick_d = ext_rise;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pre_q    <= TCU_PRE_RST;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
         tick_q   <= 1'b0;
      end else if (clk_en) begin
         pre_q    <= pre_q + 1'b1;
         ext_s1_q <= external_count_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         tick_q   <= tick_d;
      end
   end
   assign tk.tick = tick_q & clk_en;
endmodule : tcu_tick_gen

/* hw/tcu_timer.sv */
`timescale 1ns/100ps
module tcu_timer
   import tcu_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic [2:0] clock_select_field,
   input  wire logic [1:0] waveform_mode_field,
   input  wire logic [1:0] compare_output_mode_field,
   input  wire logic       external_count_input,
   input  wire logic       count_wr,
   input  wire logic [7:0] count_wdata,
   input  wire logic       compare_wr,
   input  wire logic [7:0] compare_wdata,
   input  wire logic       force_compare_strobe,
   input  wire logic       flag_wr,
   input  wire logic [1:0] flag_wdata,
   input  wire logic       overflow_int_enable,
   input  wire logic       compare_interrupt_enable,
   input  wire logic       global_int_enable,
   input  wire logic       overflow_int_ack,
   input  wire logic       compare_int_ack,
   output logic [7:0]      count_value,
   output logic [7:0]      compare_value,
   output logic [1:0]      timer_flag_register,
   output logic [1:0]      timer_mask_register,
   output logic            overflow_int_req,
   output logic            compare_int_req,
   output logic            compare_output
);
   tcu_tick_if tk ();
   tcu_wg_type wg;
   logic [7:0] cnt_q, cnt_d, act_q, act_d, buf_q, buf_d, top;
   logic       down_q, down_d, blk_q, blk_d;
   logic       ovf_q, ovf_d, ocf_q, ocf_d, oc_q, oc_d;
   logic       ovf_req_q, cmp_req_q;
   logic       tick, pwm, at_top, at_bottom, match, match_ok, upd_pt, ovf_ev;

   tcu_tick_gen u_tick (
      .core_clk             (core_clk),
      .reset                (reset),
      .clk_en               (clk_en),
      .clock_select_field   (clock_select_field),
      .external_count_input (external_count_input),
      .tk                   (tk.src)
   );

   assign tick      = tk.tick;
   assign wg        = tcu_wg_type'(waveform_mode_field);
   assign pwm       = (wg == TCU_WG_PHASE) || (wg == TCU_WG_FAST);
   assign top       = (wg == TCU_WG_CTC) ? act_q : TCU_MAX;
   assign at_top    = (cnt_q == top);
   assign at_bottom = (cnt_q == TCU_BOTTOM);
   assign match     = (cnt_q == act_q);
   assign match_ok  = tick && match && !blk_q;
   assign upd_pt    = (wg == TCU_WG_PHASE) ? (cnt_q == TCU_MAX) : at_top;

   // Next count, direction and overflow event per mode.
   always_comb begin
      cnt_d  = cnt_q;
      down_d = down_q;
      ovf_ev = 1'b0;
      if (tick) begin
         unique case (wg)
            TCU_WG_NORMAL: begin
               cnt_d  = cnt_q + 8'h01;
               ovf_ev = (cnt_q == TCU_MAX);
            end
            TCU_WG_CTC: begin
               cnt_d  = match ? TCU_BOTTOM : cnt_q + 8'h01;
               ovf_ev = (cnt_q == TCU_MAX);
            end
            TCU_WG_FAST: begin
               cnt_d  = at_top ? TCU_BOTTOM : cnt_q + 8'h01;
               ovf_ev = at_top;
            end
            TCU_WG_PHASE: begin
               if (!down_q && cnt_q == TCU_MAX) begin
                  down_d = 1'b1;
                  cnt_d  = cnt_q - 8'h01;
               end else if (down_q && at_bottom) begin
                  down_d = 1'b0;
                  cnt_d  = cnt_q + 8'h01;
                  ovf_ev = 1'b1;
               end else begin
                  cnt_d  = down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
               end
            end
         endcase
      end
      if (count_wr) begin
         cnt_d = count_wdata;
      end
   end

   // Blocking lasts until the first tick after a count write.
   assign blk_d = count_wr ? 1'b1 : (tick ? 1'b0 : blk_q);

   // Compare register path: buffer in PWM, direct otherwise.
   assign buf_d = compare_wr ? compare_wdata : (pwm ? buf_q : act_q);
   always_comb begin
      act_d = act_q;
      if (!pwm) begin
         if (compare_wr) begin
            act_d = compare_wdata;
         end
      end else if (tick && upd_pt) begin
         act_d = buf_q;
      end
   end

   // Output register; mode changes leave it untouched.
   always_comb begin
      oc_d = oc_q;
      if (!pwm && (match_ok || force_compare_strobe)) begin
         unique case (compare_output_mode_field)
            TCU_COM_OFF:    oc_d = oc_q;
            TCU_COM_TOGGLE: oc_d = ~oc_q;
            TCU_COM_CLEAR:  oc_d = 1'b0;
            TCU_COM_SET:    oc_d = 1'b1;
         endcase
      end else if (pwm && compare_output_mode_field[1]) begin
         if (wg == TCU_WG_FAST) begin
            if (match_ok && act_q != TCU_MAX) begin
               oc_d = compare_output_mode_field[0];
            end else if (tick && at_top) begin
               oc_d = ~compare_output_mode_field[0];
            end
         end else if (match_ok) begin
            oc_d = compare_output_mode_field[0] ^ down_q;
         end else if (tick && at_bottom && act_q == TCU_MAX) begin
            oc_d = compare_output_mode_field[0];
         end
      end
   end

   // Sticky flags: set wins over a clear in the same cycle.
   assign ovf_d = ovf_ev ||
                  (ovf_q && !(flag_wr && flag_wdata[0]) && !overflow_int_ack);
   assign ocf_d = match_ok ||
                  (ocf_q && !(flag_wr && flag_wdata[1]) && !compare_int_ack);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_q      <= TCU_COUNT_RST;
         act_q      <= TCU_CMP_RST;
         buf_q      <= TCU_CMP_RST;
         down_q     <= 1'b0;
         blk_q      <= 1'b0;
         ovf_q      <= 1'b0;
         ocf_q      <= 1'b0;
         oc_q       <= 1'b0;
         ovf_req_q  <= 1'b0;
         cmp_req_q  <= 1'b0;
      end else if (clk_en) begin
         cnt_q      <= cnt_d;
         act_q      <= act_d;
         buf_q      <= buf_d;
         down_q     <= (wg == TCU_WG_PHASE) ? down_d : 1'b0;
         blk_q      <= blk_d;
         ovf_q      <= ovf_d;
         ocf_q      <= ocf_d;
         oc_q       <= oc_d;
         ovf_req_q  <= ovf_d && overflow_int_enable && global_int_enable;
         cmp_req_q  <= ocf_d && compare_interrupt_enable && global_int_enable;
      end
   end

   // Reads show the buffer in PWM modes and the active value otherwise.
   logic [7:0] cmp_rd_q;
   logic [1:0] mask_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cmp_rd_q <= TCU_CMP_RST;
         mask_q   <= 2'h0;
      end else if (clk_en) begin
         cmp_rd_q <= pwm ? buf_d : act_d;
         mask_q   <= {compare_interrupt_enable, overflow_int_enable};
      end
   end

   assign count_value         = cnt_q;
   assign compare_value       = cmp_rd_q;
   assign timer_flag_register = {ocf_q, ovf_q};
   assign timer_mask_register = mask_q;
   assign overflow_int_req    = ovf_req_q;
   assign compare_int_req     = cmp_req_q;
   assign compare_output      = oc_q;

   // Checks on the counter, the flags and the output register.
   property p_stop_holds;
      @(posedge core_clk) disable iff (reset)
         (clock_select_field == TCU_CS_STOP && clk_en && !count_wr) [*3]
            |=> $stable(cnt_q);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

   property p_wr_wins;
      @(posedge core_clk) disable iff (reset)
         (count_wr && clk_en) |=> (cnt_q == $past(count_wdata));
   endproperty
   a_wr_wins: assert property (p_wr_wins) else $error("count write lost");

   property p_flag_next;
      @(posedge core_clk) disable iff (reset)
         (clk_en && tick && match && !blk_q) |=> ocf_q;
   endproperty
   a_flag_next: assert property (p_flag_next) else $error("match flag not set");

   // A count write arms the block; a tick in the very next cycle must not raise the match flag.
   sequence s_cnt_written;
      clk_en && count_wr && !ocf_q;
   endsequence

   sequence s_blocked_tick;
      clk_en && tick && !count_wr && !flag_wr && !compare_int_ack && !ocf_q;
   endsequence

   property p_block;
      @(posedge core_clk) disable iff (reset)
         s_cnt_written ##1 s_blocked_tick |=> (ocf_q == 1'b0);
   endproperty
   a_block: assert property (p_block) else $error("match after count write");

   property p_req;
      @(posedge core_clk) disable iff (reset)
         (cmp_req_q && $past(clk_en)) |-> (timer_flag_register[1]
            && $past(compare_interrupt_enable) && $past(global_int_enable));
   endproperty
   a_req: assert property (p_req) else $error("compare request ungated");

   property p_normal_wrap;
      @(posedge core_clk) disable iff (reset)
         (clk_en && tick && wg == TCU_WG_NORMAL && cnt_q == TCU_MAX && !count_wr)
            |=> (cnt_q == TCU_BOTTOM) && ovf_q;
   endproperty
   a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

   property p_ctc_clear;
      @(posedge core_clk) disable iff (reset)
         (clk_en && tick && wg == TCU_WG_CTC && match && !count_wr)
            |=> (cnt_q == TCU_BOTTOM);
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) else $error("clear on match failed");

   property p_force_noflag;
      @(posedge core_clk) disable iff (reset)
         (clk_en && force_compare_strobe && !pwm && !tick && !ocf_q && !count_wr)
            |=> !ocf_q && $stable(cnt_q);
   endproperty
   a_force_noflag: assert property (p_force_noflag) else $error("force touched flag");

   property p_direct;
      @(posedge core_clk) disable iff (reset)
         (clk_en && compare_wr && !pwm && $past(!pwm)) |=> (act_q == $past(compare_wdata));
   endproperty
   a_direct: assert property (p_direct) else $error("direct compare write lost");

   property p_fast_wrap;
      @(posedge core_clk) disable iff (reset)
         (clk_en && tick && wg == TCU_WG_FAST && cnt_q == TCU_MAX && !count_wr)
            |=> (cnt_q == TCU_BOTTOM) && ovf_q;
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap wrong");

   // Phase-correct turns down at the maximum and reports overflow at the bottom.
   sequence s_phase_top;
      clk_en && tick && wg == TCU_WG_PHASE && !down_q && cnt_q == TCU_MAX && !count_wr;
   endsequence

   sequence s_phase_bottom;
      clk_en && tick && wg == TCU_WG_PHASE && down_q && at_bottom && !count_wr;
   endsequence

   property p_phase_turn;
      @(posedge core_clk) disable iff (reset)
         s_phase_top |=> down_q && (cnt_q == TCU_MAX - 8'h01);
   endproperty
   a_phase_turn: assert property (p_phase_turn) else $error("phase turn wrong");

   property p_phase_ovf;
      @(posedge core_clk) disable iff (reset)
         s_phase_bottom |=> ovf_q && !down_q && (cnt_q == TCU_BOTTOM + 8'h01);
   endproperty
   a_phase_ovf: assert property (p_phase_ovf) else $error("phase overflow wrong");

   property p_buf_load;
      @(posedge core_clk) disable iff (reset)
         (clk_en && tick && pwm && upd_pt) |=> (act_q == $past(buf_q));
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("buffer not loaded");

   property p_rst_out;
      @(posedge core_clk) reset |=> (oc_q == 1'b0) && (cnt_q == TCU_COUNT_RST);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset state wrong");

   property p_force_out;
      @(posedge core_clk) disable iff (reset)
         (clk_en && force_compare_strobe && !pwm && compare_output_mode_field == TCU_COM_SET)
            |=> oc_q;
   endproperty
   a_force_out: assert property (p_force_out) else $error("forced set lost");

   property p_pwm_no_force;
      @(posedge core_clk) disable iff (reset)
         (clk_en && force_compare_strobe && pwm && !tick) |=> $stable(oc_q);
   endproperty
   a_pwm_no_force: assert property (p_pwm_no_force) else $error("force acted in pwm");

   property p_hold_en;
      @(posedge core_clk) disable iff (reset)
         !clk_en |=> $stable(cnt_q) && $stable(oc_q) && $stable(timer_flag_register);
   endproperty
   a_hold_en: assert property (p_hold_en) else $error("state moved while frozen");
endmodule : tcu_timer

/* shared/tcu_pkg.sv */
package tcu_pkg;
   localparam logic [7:0] TCU_BOTTOM      = 8'h00;
   localparam logic [7:0] TCU_MAX         = 8'hff;
   localparam logic [7:0] TCU_COUNT_RST   = 8'h00;
   localparam logic [7:0] TCU_CMP_RST     = 8'h00;
   localparam logic [2:0] TCU_CS_STOP     = 3'h0;
   localparam logic [2:0] TCU_CS_DIV1     = 3'h1;
   localparam logic [2:0] TCU_CS_DIV8     = 3'h2;
   localparam logic [2:0] TCU_CS_DIV64    = 3'h3;
   localparam logic [2:0] TCU_CS_DIV256   = 3'h4;
   localparam logic [2:0] TCU_CS_DIV1024  = 3'h5;
   localparam logic [2:0] TCU_CS_EXT_FALL = 3'h6;
   localparam logic [9:0] TCU_PRE_RST     = 10'h000;
   localparam int         TCU_PRE_WIDTH   = 10;
   typedef enum logic [1:0] {
      TCU_WG_NORMAL,
      TCU_WG_PHASE,
      TCU_WG_CTC,
      TCU_WG_FAST
   } tcu_wg_type;
   localparam logic [1:0] TCU_COM_OFF    = 2'h0;
   localparam logic [1:0] TCU_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCU_COM_CLEAR  = 2'h2;
   localparam logic [1:0] TCU_COM_SET    = 2'h3;
endpackage : tcu_pkg

/* shared/tcu_tick_if.sv */
`timescale 1ns/100ps
interface tcu_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface : tcu_tick_if

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
   import tcu_pkg::*;
   logic       core_clk = 1'b0;
   logic       reset    = 1'b1;
   logic [2:0] cs       = 3'h0;
   logic [1:0] wg       = 2'h0;
   logic [1:0] com      = 2'h0;
   logic       ext      = 1'b0;
   logic       cwr      = 1'b0;
   logic       mwr      = 1'b0;
   logic       fwr      = 1'b0;
   logic       frc      = 1'b0;
   logic [7:0] wd       = 8'h00;
   logic       oie      = 1'b0;
   logic       cie      = 1'b0;
   logic       gie      = 1'b0;
   logic       svc_en   = 1'b0;
   logic       en       = 1'b1;
   logic [7:0] cnt, cmp, mx, a;
   logic [1:0] flg, msk;
   logic       oreq, creq, oc, pv;
   wire  [1:0] ack_w;
   int         n_fail    = 0;
   int         cmp_count = 0;
   int         tg;

   always #25 core_clk = ~core_clk;

   tcu_timer DUT (.core_clk(core_clk), .reset(reset), .clk_en(en),
      .clock_select_field(cs), .waveform_mode_field(wg), .compare_output_mode_field(com),
      .external_count_input(ext), .count_wr(cwr), .count_wdata(wd), .compare_wr(mwr),
      .compare_wdata(wd), .force_compare_strobe(frc), .flag_wr(fwr), .flag_wdata(wd[1:0]),
      .overflow_int_enable(oie), .compare_interrupt_enable(cie), .global_int_enable(gie),
      .overflow_int_ack(ack_w[0]), .compare_int_ack(ack_w[1]), .count_value(cnt),
      .compare_value(cmp), .timer_flag_register(flg), .timer_mask_register(msk),
      .overflow_int_req(oreq), .compare_int_req(creq), .compare_output(oc));

   tcu_host_model #(.LAT(4)) host (.core_clk(core_clk), .reset(reset), .svc_en(svc_en),
      .int_req({creq, oreq}), .int_ack(ack_w));

   task print_verdict;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   task cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   task chk(input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   // Kind 0 writes the count, 1 the compare value, 2 the flags, 3 pulses the force strobe.
   task wr(input int k, input logic [7:0] v);
      @(negedge core_clk);
      wd  = v;
      cwr = (k == 0);
      mwr = (k == 1);
      fwr = (k == 2);
      frc = (k == 3);
      @(negedge core_clk);
      {cwr, mwr, fwr, frc} = 4'h0;
   endtask : wr

   task cfg(input logic [2:0] c, input logic [1:0] w, input logic [1:0] m);
      @(negedge core_clk);
      cs  = c;
      wg  = w;
      com = m;
   endtask : cfg

   task wait_flag(input int b, input logic v);
      for (int i = 0; i < 600 && flg[b] !== v; i++) cyc(1);
      chk({7'h0, v}, {7'h0, flg[b]});
   endtask : wait_flag

   task wait_cnt(input logic [7:0] v);
      for (int i = 0; i < 600 && cnt !== v; i++) cyc(1);
      chk(v, cnt);
   endtask : wait_cnt

   // Tracks the highest count and the output toggles over n cycles.
   task watch(input int n);
      mx = 8'h00;
      tg = 0;
      pv = oc;
      repeat (n) begin
         cyc(1);
         if (cnt > mx) mx = cnt;
         if (oc !== pv) tg++;
         pv = oc;
      end
   endtask : watch

   initial begin
      #500000;
      n_fail++;
      print_verdict();
   end

   initial begin
      cyc(8);
      reset = 1'b0;
      cyc(1);
      chk(8'h00, cnt);
      chk(8'h00, {7'h0, oc});
      chk(8'h00, {6'h0, flg});
      wr(0, 8'h55);
      chk(8'h55, cnt);
      cyc(10);
      chk(8'h55, cnt);
      cfg(TCU_CS_STOP, TCU_WG_NORMAL, TCU_COM_SET);
      wr(3, 8'h00);
      chk(8'h01, {7'h0, oc});
      chk(8'h00, {6'h0, flg});
      chk(8'h55, cnt);
      cfg(TCU_CS_STOP, TCU_WG_NORMAL, TCU_COM_CLEAR);
      wr(3, 8'h00);
      chk(8'h00, {7'h0, oc});
      cfg(TCU_CS_STOP, TCU_WG_CTC, TCU_COM_TOGGLE);
      wr(3, 8'h00);
      chk(8'h01, {7'h0, oc});
      cfg(TCU_CS_STOP, TCU_WG_NORMAL, TCU_COM_OFF);
      wr(3, 8'h00);
      chk(8'h01, {7'h0, oc});
      cfg(TCU_CS_STOP, TCU_WG_FAST, TCU_COM_CLEAR);
      wr(3, 8'h00);
      chk(8'h01, {7'h0, oc});
      cfg(TCU_CS_EXT_FALL, TCU_WG_NORMAL, TCU_COM_OFF);
      wr(0, 8'h00);
      repeat (5) begin
         ext = 1'b1;
         cyc(3);
         ext = 1'b0;
         cyc(3);
      end
      cyc(4);
      chk(8'h05, cnt);
      cfg(TCU_CS_STOP, TCU_WG_NORMAL, TCU_COM_OFF);
      oie    = 1'b1;
      gie    = 1'b1;
      svc_en = 1'b1;
      cyc(2);
      chk(8'h01, {6'h0, msk});
      wr(0, 8'hfd);
      cfg(TCU_CS_DIV1, TCU_WG_NORMAL, TCU_COM_OFF);
      wait_flag(0, 1'b1);
      chk(8'h01, {7'h0, oreq});
      wait_flag(0, 1'b0);
      cfg(TCU_CS_STOP, TCU_WG_CTC, TCU_COM_TOGGLE);
      {oie, gie, cie} = 3'b001;
      wr(1, 8'h05);
      chk(8'h05, cmp);
      wr(0, 8'h00);
      cfg(TCU_CS_DIV1, TCU_WG_CTC, TCU_COM_TOGGLE);
      watch(40);
      chk(8'h05, mx);
      chk(8'h01, {7'h0, tg >= 5});
      wait_flag(1, 1'b1);
      cfg(TCU_CS_STOP, TCU_WG_CTC, TCU_COM_TOGGLE);
      cyc(2);
      chk(8'h00, {7'h0, creq});
      wr(2, 8'h02);
      chk(8'h00, {7'h0, flg[1]});
      cfg(TCU_CS_STOP, TCU_WG_NORMAL, TCU_COM_OFF);
      wr(0, 8'h05);
      cfg(TCU_CS_DIV1, TCU_WG_NORMAL, TCU_COM_OFF);
      cyc(20);
      chk(8'h00, {7'h0, flg[1]});
      en = 1'b0;
      a  = cnt;
      cyc(5);
      chk(a, cnt);
      en = 1'b1;
      wr(0, 8'h02);
      wait_flag(1, 1'b1);
      gie = 1'b1;
      cyc(2);
      chk(8'h01, {7'h0, creq});
      wait_flag(1, 1'b0);
      cfg(TCU_CS_DIV1, TCU_WG_FAST, TCU_COM_CLEAR);
      wr(1, 8'h10);
      chk(8'h10, cmp);
      wr(0, 8'h80);
      chk(8'h80, cnt);
      watch(300);
      chk(8'hff, mx);
      wait_cnt(8'h40);
      chk(8'h00, {7'h0, oc});
      wait_cnt(8'h08);
      chk(8'h01, {7'h0, oc});
      cfg(TCU_CS_DIV1, TCU_WG_PHASE, TCU_COM_SET);
      wait_cnt(8'hff);
      cyc(4);
      a = cnt;
      cyc(1);
      chk(a - 8'h01, cnt);
      wr(2, 8'h01);
      chk(8'h00, {7'h0, flg[0]});
      wait_cnt(8'h01);
      cyc(3);
      chk(8'h02, cnt);
      chk(8'h01, {7'h0, flg[0]});
      print_verdict();
   end
endmodule : tb

/* tb/tcu_host_model.sv */
`timescale 1ns/100ps
module tcu_host_model #(
   parameter int LAT = 4
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       svc_en,
   input  wire logic [1:0] int_req,
   output logic [1:0]      int_ack = 2'h0
);
   int wait_q [2];

   // The host enters the handler a few cycles after a request rises and acknowledges once.
   always @(negedge core_clk) begin
      for (int i = 0; i < 2; i++) begin
         if (reset || !svc_en || int_ack[i] || !int_req[i]) begin
            wait_q[i] <= 0;
         end else begin
            wait_q[i] <= wait_q[i] + 1;
         end
         int_ack[i] <= (wait_q[i] == LAT) && int_req[i] && svc_en && !reset;
      end
   end
endmodule : tcu_host_model
